// ---- hdl/pfr_pkg.sv ----
// Constants, mode codes and register map of the port function router
package pfr_pkg;
	// Port and parameter widths
	localparam int PORT_W = 32;
	localparam int FSEL_W = 4;
	localparam int FREQ_W = 32;
	localparam int PHASE_W = 16;
	localparam int AMPW_W = 16;
	localparam int AMPC_W = 12;
	localparam int PADDR_W = 8;

	// Function-select codes
	localparam logic [3:0] MODE_REG_PROG = 4'h0;
	localparam logic [3:0] MODE_SERIAL = 4'h1;
	localparam logic [3:0] MODE_FREQ_FULL = 4'h2;
	localparam logic [3:0] MODE_FREQ_SWAP = 4'h3;
	localparam logic [3:0] MODE_PHASE_AMP = 4'h4;
	localparam logic [3:0] MODE_AMP_PHASE = 4'h5;
	localparam logic [3:0] MODE_HI_AMP_HI = 4'h6;
	localparam logic [3:0] MODE_HI_PH_HI = 4'h7;
	localparam logic [3:0] MODE_HI_AMP_LO = 4'h8;
	localparam logic [3:0] MODE_HI_PH_LO = 4'h9;
	localparam logic [3:0] MODE_LO_AMP_HI = 4'ha;
	localparam logic [3:0] MODE_LO_PH_HI = 4'hb;
	localparam logic [3:0] MODE_LO_AMP_LO = 4'hc;
	localparam logic [3:0] MODE_LO_PH_LO = 4'hd;

	// Register-programming control bits in the low byte
	localparam int CTL_WRITE = 0;
	localparam int CTL_READ = 1;
	localparam int CTL_WIDE = 2;
	localparam logic [15:0] OE_WIDE = 16'hffff;
	localparam logic [15:0] OE_NARROW = 16'h00ff;

	// Serial pin positions in the low byte
	localparam int SER_CS = 0;
	localparam int SER_SCLK = 1;
	localparam int SER_SDIO = 2;
	localparam int SER_SDO = 3;
	localparam int SER_SYNC = 4;

	// Sample divider: one port sample per 24 clocks
	localparam int SAMPLE_DIV = 24;
	localparam logic [4:0] TICK_LAST = 5'(SAMPLE_DIV - 1);

	// APB register byte offsets
	localparam logic [7:0] REG_CTRL0 = 8'h00;
	localparam logic [7:0] REG_CTRL1 = 8'h04;
	localparam logic [7:0] REG_FREQ = 8'h08;
	localparam logic [7:0] REG_PHASE = 8'h0c;
	localparam logic [7:0] REG_AMP = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_UPDATE = 8'h18;

	// Control field positions
	localparam int STREAM_BIT = 17;
	localparam int KEYING_BIT = 8;
	localparam int UPDATE_BIT = 0;

	// Reset values
	localparam logic [31:0] CTRL0_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL1_RESET = 32'h0000_0000;

	// Codes that deliver parameter words directly
	function automatic logic pfr_is_direct(input logic [3:0] code);
		return (code >= MODE_FREQ_FULL) && (code <= MODE_LO_PH_LO);
	endfunction : pfr_is_direct

	// Offsets that answer on the bus
	function automatic logic pfr_reg_known(input logic [7:0] addr);
		return (addr == REG_CTRL0) || (addr == REG_CTRL1) || (addr == REG_FREQ) || (addr == REG_PHASE)
			|| (addr == REG_AMP) || (addr == REG_STATUS) || (addr == REG_UPDATE);
	endfunction : pfr_reg_known
endpackage : pfr_pkg

// ---- hdl/pfr_route_if.sv ----
// Carrier between the port controller and the word router
`timescale 1ns/100ps
interface pfr_route_if;
	import pfr_pkg::*;
	logic [3:0] code; // Active function-select code
	logic [31:0] portWord; // Synchronised port word
	logic [31:0] freqNow; // Held tuning word
	logic [15:0] phaseNow; // Held phase word
	logic [15:0] ampNow; // Held amplitude word
	logic [31:0] freqNext; // Routed tuning word
	logic [15:0] phaseNext; // Routed phase word
	logic [15:0] ampNext; // Routed amplitude word
	modport router (input code, portWord, freqNow, phaseNow, ampNow, output freqNext, phaseNext, ampNext);
	modport user (output code, portWord, freqNow, phaseNow, ampNow, input freqNext, phaseNext, ampNext);
endinterface : pfr_route_if

// ---- hdl/pfr_word_router.sv ----
// Routes the port word onto tuning, phase and amplitude words per code
`timescale 1ns/100ps
module pfr_word_router
	import pfr_pkg::*;
(
	pfr_route_if.router rt
);
	// Start from held words; each code overwrites only its own bits
	always_comb begin
		rt.freqNext = rt.freqNow; // R17
		rt.phaseNext = rt.phaseNow;
		rt.ampNext = rt.ampNow;
		case (rt.code)
			MODE_FREQ_FULL: begin
				rt.freqNext = rt.portWord; // R6
			end
			MODE_FREQ_SWAP: begin
				rt.freqNext = {rt.portWord[15:0], rt.portWord[31:16]}; // R7
			end
			MODE_PHASE_AMP: begin
				rt.phaseNext = rt.portWord[31:16]; // R8
				rt.ampNext[11:0] = rt.portWord[11:0]; // R8
			end
			MODE_AMP_PHASE: begin
				rt.ampNext[11:0] = rt.portWord[27:16]; // R9
				rt.phaseNext = rt.portWord[15:0]; // R9
			end
			MODE_HI_AMP_HI, MODE_HI_PH_HI, MODE_HI_AMP_LO, MODE_HI_PH_LO: begin
				rt.freqNext[31:8] = rt.portWord[31:8]; // R10
			end
			MODE_LO_AMP_HI, MODE_LO_PH_HI, MODE_LO_AMP_LO, MODE_LO_PH_LO: begin
				rt.freqNext[23:0] = rt.portWord[31:8]; // R11
			end
			default: begin
				// Other codes leave all words alone
			end
		endcase
		// Low byte destinations of the partial modes
		case (rt.code)
			MODE_HI_AMP_HI, MODE_LO_AMP_HI: rt.ampNext[15:8] = rt.portWord[7:0]; // R10 R11
			MODE_HI_PH_HI, MODE_LO_PH_HI: rt.phaseNext[15:8] = rt.portWord[7:0]; // R10 R11
			MODE_HI_AMP_LO, MODE_LO_AMP_LO: rt.ampNext[7:0] = rt.portWord[7:0]; // R10 R11
			MODE_HI_PH_LO, MODE_LO_PH_LO: rt.phaseNext[7:0] = rt.portWord[7:0]; // R10 R11
			default: begin
				// No low byte routing
			end
		endcase
	end
endmodule : pfr_word_router

// ---- hdl/port_function_router.sv ----
// Top of the port function router: pins, APB registers, parameter words
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/100ps
// What this block does
// [R1] Function-select pins pick one port role
// [R2] Code 0000: data, address, control fields
// [R3] Control picks read/write and 8/16 width
// [R4] Address picks register; data carries content
// [R5] Code 0001: low byte is serial pins
// [R6] Code 0010: port straight into tuning word
// [R7] Code 0011: tuning word with halves swapped
// [R8] Code 0100: phase high, amplitude low
// [R9] Code 0101: amplitude high, phase low
// [R10] Codes 0110-1001: tuning 31:8 plus byte
// [R11] Codes 1010-1101: tuning 23:0 plus byte
// [R12] Amplitude acts only with keying enabled
// [R13] Amplitude bits 15:12 never reach output
// [R14] Codes 1110, 1111 do nothing
// [R15] Streaming direct to core, else update strobe
// [R16] Port sampled once per 24 clocks
// [R17] Partial modes keep untouched bits
module port_function_router
	import pfr_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] funcSelPin,
	input wire logic [31:0] portPinIn,
	output logic [31:0] portPinOut,
	output logic [31:0] portPinOe,
	input wire logic ioUpdatePin,
	output logic serialClk,
	output logic serialDataIoIn,
	output logic serialChipSelN,
	output logic serialSyncAbort,
	input wire logic serialDataOut,
	input wire logic serialDataIoOut,
	input wire logic serialDataIoOe,
	output logic [31:0] coreFreq,
	output logic [15:0] corePhase,
	output logic [11:0] coreAmp
);
	logic [31:0] portSync1; // First stage, read only by second
	logic [31:0] portSync2; // Stable port word
	logic [3:0] fselSync1; // First stage of select pins
	logic [3:0] fselSync2; // Stable select code
	logic updSync1; // First stage of update pin
	logic updSync2; // Stable update level
	logic updLast; // Previous update level
	logic [4:0] tickCount; // Sample divider
	logic tick; // One-cycle sample enable
	logic [31:0] ctrl0; // Streaming control
	logic [31:0] ctrl1; // Keying control
	logic [31:0] freqHeld; // Parameter register, tuning
	logic [15:0] phaseHeld; // Parameter register, phase
	logic [15:0] ampHeld; // Parameter register, amplitude
	logic [15:0] progRegs [256]; // Parallel-programmed registers
	logic streamEnable; // Direct words go to core
	logic keyingEnable; // Amplitude allowed through
	logic directLoad; // Direct sample this cycle
	logic apbWrite; // Write completes this edge
	logic swUpdate; // Software update strobe
	logic updateEvent; // Pin or software update
	logic progWrite; // Port register write this tick
	logic [7:0] progAddr; // Port register address field
	logic [31:0] readMux; // APB read data
	logic [31:0] next_prdata; // Read value loaded into prdata, zero on writes

	pfr_route_if rt();

	// Word router instance
	pfr_word_router i_pfr_word_router (
		.rt(rt.router)
	);

	assign rt.code = fselSync2;
	assign rt.portWord = portSync2;
	assign rt.freqNow = freqHeld;
	assign rt.phaseNow = phaseHeld;
	assign rt.ampNow = ampHeld;

	// Two-stage synchronisers for all pins
	always_ff @(posedge clk) begin
		if (reset) begin
			portSync1 <= 32'h0000_0000;
			portSync2 <= 32'h0000_0000;
			fselSync1 <= 4'hf;
			fselSync2 <= 4'hf;
			updSync1 <= 1'b0;
			updSync2 <= 1'b0;
			updLast <= 1'b0;
		end else begin
			portSync1 <= portPinIn;
			portSync2 <= portSync1;
			fselSync1 <= funcSelPin;
			fselSync2 <= fselSync1; // R1
			updSync1 <= ioUpdatePin;
			updSync2 <= updSync1;
			updLast <= updSync2;
		end
	end

	// Sample divider producing the port sample enable
	always_ff @(posedge clk) begin
		if (reset) begin
			tickCount <= 5'h00;
			tick <= 1'b0;
		end else begin
			tick <= (tickCount == TICK_LAST); // R16
			tickCount <= (tickCount == TICK_LAST) ? 5'h00 : tickCount + 5'h01; // R16
		end
	end

	assign streamEnable = ctrl0[STREAM_BIT];
	assign keyingEnable = ctrl1[KEYING_BIT];
	assign directLoad = tick && pfr_is_direct(fselSync2); // R1 R14
	assign apbWrite = psel && penable && pready && pwrite;
	assign swUpdate = apbWrite && (paddr == REG_UPDATE) && pwdata[UPDATE_BIT];
	assign updateEvent = (updSync2 && !updLast) || swUpdate;
	assign progAddr = portSync2[15:8]; // R2
	assign progWrite = tick && (fselSync2 == MODE_REG_PROG) && portSync2[CTL_WRITE]; // R2 R3

	// Parameter registers take routed words on each direct sample
	always_ff @(posedge clk) begin
		if (reset) begin
			freqHeld <= 32'h0000_0000;
			phaseHeld <= 16'h0000;
			ampHeld <= 16'h0000;
		end else if (directLoad) begin
			freqHeld <= rt.freqNext; // R6 R7 R10 R11 R17
			phaseHeld <= rt.phaseNext; // R8 R9 R17
			ampHeld <= rt.ampNext; // R8 R9 R17
		end
	end

	// Core tuning and phase: streamed or on update
	always_ff @(posedge clk) begin
		if (reset) begin
			coreFreq <= 32'h0000_0000;
			corePhase <= 16'h0000;
		end else if (directLoad && streamEnable) begin
			coreFreq <= rt.freqNext; // R15
			corePhase <= rt.phaseNext; // R15
		end else if (updateEvent) begin
			coreFreq <= freqHeld; // R15
			corePhase <= phaseHeld; // R15
		end
	end

	// Core amplitude: only low twelve bits, only with keying
	always_ff @(posedge clk) begin
		if (reset) begin
			coreAmp <= 12'h000;
		end else if (keyingEnable) begin // R12
			if (directLoad && streamEnable) begin
				coreAmp <= rt.ampNext[11:0]; // R13 R15
			end else if (updateEvent) begin
				coreAmp <= ampHeld[11:0]; // R13 R15
			end
		end
	end

	// Port register writes, 16-bit or low byte only
	always_ff @(posedge clk) begin
		if (progWrite) begin
			if (portSync2[CTL_WIDE]) begin
				progRegs[progAddr] <= portSync2[31:16]; // R3 R4
			end else begin
				progRegs[progAddr][7:0] <= portSync2[23:16]; // R3 R4
			end
		end
	end

	// Port drivers: register readback or serial outputs
	always_ff @(posedge clk) begin
		if (reset) begin
			portPinOut <= 32'h0000_0000;
			portPinOe <= 32'h0000_0000;
		end else begin
			portPinOut <= 32'h0000_0000;
			portPinOe <= 32'h0000_0000;
			case (fselSync2)
				MODE_REG_PROG: begin
					if (portSync2[CTL_READ] && !portSync2[CTL_WRITE]) begin
						portPinOut[31:16] <= progRegs[progAddr]; // R4
						portPinOe[31:16] <= portSync2[CTL_WIDE] ? OE_WIDE : OE_NARROW; // R3
					end
				end
				MODE_SERIAL: begin
					portPinOut[SER_SDO] <= serialDataOut; // R5
					portPinOe[SER_SDO] <= 1'b1; // R5
					portPinOut[SER_SDIO] <= serialDataIoOut;
					portPinOe[SER_SDIO] <= serialDataIoOe;
				end
				default: begin
					// Port not driven
				end
			endcase
		end
	end

	// Serial pins follow the low byte only in serial mode
	always_ff @(posedge clk) begin
		if (reset) begin
			serialClk <= 1'b0;
			serialDataIoIn <= 1'b0;
			serialChipSelN <= 1'b1;
			serialSyncAbort <= 1'b0;
		end else if (fselSync2 == MODE_SERIAL) begin
			serialClk <= portSync2[SER_SCLK]; // R5
			serialDataIoIn <= portSync2[SER_SDIO]; // R5
			serialChipSelN <= portSync2[SER_CS]; // R5
			serialSyncAbort <= portSync2[SER_SYNC]; // R5
		end else begin
			serialChipSelN <= 1'b1; // Idle serial link
		end
	end

	// Control registers written over APB
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl0 <= CTRL0_RESET;
			ctrl1 <= CTRL1_RESET;
		end else if (apbWrite) begin
			if (paddr == REG_CTRL0) begin
				ctrl0 <= pwdata;
			end
			if (paddr == REG_CTRL1) begin
				ctrl1 <= pwdata;
			end
		end
	end

	// APB read selection
	always_comb begin
		readMux = 32'h0000_0000;
		case (paddr)
			REG_CTRL0: readMux = ctrl0;
			REG_CTRL1: readMux = ctrl1;
			REG_FREQ: readMux = coreFreq;
			REG_PHASE: readMux = {16'h0000, corePhase};
			REG_AMP: readMux = {20'h00000, coreAmp};
			REG_STATUS: readMux = {26'h0000000, !pfr_is_direct(fselSync2) && (fselSync2 > MODE_SERIAL),
				(freqHeld != coreFreq), fselSync2}; // R14
			default: readMux = 32'h0000_0000;
		endcase
		next_prdata = pwrite ? 32'h0000_0000 : readMux;
	end

	// APB answer: one wait state, error on unmapped offset
	always_ff @(posedge clk) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= !pfr_reg_known(paddr);
			prdata <= next_prdata;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Checks on the sampled datapath
	property p_tick_period;
		@(posedge clk) disable iff (reset) tick |-> ##24 tick;
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("sample enable not every 24 clocks"); // R16

	property p_freq_full;
		@(posedge clk) disable iff (reset) (tick && fselSync2 == MODE_FREQ_FULL) |=> freqHeld == $past(portSync2);
	endproperty
	a_freq_full: assert property (p_freq_full) else $error("full tuning load wrong"); // R6

	property p_freq_swap;
		@(posedge clk) disable iff (reset)
			(tick && fselSync2 == MODE_FREQ_SWAP) |=> freqHeld == {$past(portSync2[15:0]), $past(portSync2[31:16])};
	endproperty
	a_freq_swap: assert property (p_freq_swap) else $error("swapped tuning load wrong"); // R7

	property p_unused_idle;
		@(posedge clk) disable iff (reset)
			(fselSync2 > MODE_LO_PH_LO) |=> $stable(freqHeld) && $stable(phaseHeld) && $stable(ampHeld) && portPinOe == 32'h0;
	endproperty
	a_unused_idle: assert property (p_unused_idle) else $error("unused code changed state"); // R14

	property p_stream_core;
		@(posedge clk) disable iff (reset) (directLoad && streamEnable) |=> coreFreq == freqHeld && corePhase == phaseHeld;
	endproperty
	a_stream_core: assert property (p_stream_core) else $error("streamed word missed core"); // R15

	property p_hold_core;
		@(posedge clk) disable iff (reset) (!streamEnable && !updateEvent) |=> $stable(coreFreq) && $stable(corePhase);
	endproperty
	a_hold_core: assert property (p_hold_core) else $error("core changed without update"); // R15

	property p_keying_gate;
		@(posedge clk) disable iff (reset) !keyingEnable |=> $stable(coreAmp);
	endproperty
	a_keying_gate: assert property (p_keying_gate) else $error("amplitude moved while keying off"); // R12

	property p_amp_low;
		@(posedge clk) disable iff (reset) (directLoad && streamEnable && keyingEnable) |=> coreAmp == ampHeld[11:0];
	endproperty
	a_amp_low: assert property (p_amp_low) else $error("amplitude core not from low twelve bits"); // R13

	property p_partial_keep;
		@(posedge clk) disable iff (reset) (tick && fselSync2 == MODE_HI_AMP_LO) |=> $stable(ampHeld[15:8])
			&& $stable(phaseHeld) && freqHeld[7:0] == $past(freqHeld[7:0]);
	endproperty
	a_partial_keep: assert property (p_partial_keep) else $error("partial mode touched other bits"); // R17

	property p_serial_pass;
		@(posedge clk) disable iff (reset) (fselSync2 == MODE_SERIAL) |=> serialClk == $past(portSync2[SER_SCLK]);
	endproperty
	a_serial_pass: assert property (p_serial_pass) else $error("serial clock not passed"); // R5

	property p_narrow_read;
		@(posedge clk) disable iff (reset) (fselSync2 == MODE_REG_PROG && portSync2[CTL_READ] && !portSync2[CTL_WRITE]
			&& !portSync2[CTL_WIDE]) |=> portPinOe[31:24] == 8'h00 && portPinOe[23:16] == 8'hff;
	endproperty
	a_narrow_read: assert property (p_narrow_read) else $error("narrow read drives wrong lanes"); // R3

	property p_apb_pulse;
		@(posedge clk) disable iff (reset) pready |=> !pready;
	endproperty
	a_apb_pulse: assert property (p_apb_pulse) else $error("pready longer than one cycle");

	c_serial: cover property (@(posedge clk) disable iff (reset) fselSync2 == MODE_SERIAL ##1 serialClk);
	c_swap: cover property (@(posedge clk) disable iff (reset) tick && fselSync2 == MODE_FREQ_SWAP);
	c_update: cover property (@(posedge clk) disable iff (reset) !streamEnable && updateEvent);
	c_prog_write: cover property (@(posedge clk) disable iff (reset) progWrite);
endmodule : port_function_router

// ---- tb/pfr_host_model.sv ----
// Host controller model that drives the function-select, port and update pins
`timescale 1ns/100ps
module pfr_host_model (
	input wire logic clk,
	input wire logic [31:0] portPinOut,
	input wire logic [31:0] portPinOe,
	output logic [3:0] funcSelPin,
	output logic [31:0] portPinIn,
	output logic ioUpdatePin
);
	logic [31:0] hostVal = 32'h0; // Last word put out
	logic [31:0] hostOe = 32'hffffffff; // Bits the host drives
	// Wire level: device wins where it drives, released host bits show the inverse of the last value
	assign portPinIn = (portPinOe & portPinOut) | (~portPinOe & ((hostOe & hostVal) | (~hostOe & ~hostVal)));
	// Idle on an unused code
	initial begin
		funcSelPin = 4'hf;
		ioUpdatePin = 1'b0;
	end
	// Puts code and word on the pins just after an edge
	task automatic drive(input logic [3:0] code, input logic [31:0] word, input logic [31:0] oe);
		@(posedge clk);
		funcSelPin <= code;
		hostVal <= word;
		hostOe <= oe;
	endtask : drive
	// Holds the pins beyond one sample period plus sync
	task automatic apply(input logic [3:0] code, input logic [31:0] word, input logic [31:0] oe);
		drive(code, word, oe);
		repeat (30) @(posedge clk);
	endtask : apply
	// One rising edge on the update pin
	task automatic pulse_update();
		@(posedge clk);
		ioUpdatePin <= 1'b1;
		repeat (5) @(posedge clk);
		ioUpdatePin <= 1'b0;
		repeat (5) @(posedge clk);
	endtask : pulse_update
endmodule : pfr_host_model

// ---- tb/port_function_router_tb.sv ----
// Self-checking bench of the port function router
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin nCompared++; if ((got) !== (ex)) begin numErrors++; \
	$display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module port_function_router_tb;
	import pfr_pkg::*;
	typedef struct packed {logic [3:0] code; logic [31:0] word; logic [31:0] f; logic [15:0] p;
		logic [11:0] a;} pfr_row_t;
	logic clk = 1'b0; // Bench clock
	logic reset = 1'b1; // Sync reset
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
	logic [7:0] paddr = 8'h00; // APB address
	logic [31:0] pwdata = 32'h0, prdata; // APB data
	logic pready, pslverr; // APB answer
	logic [3:0] funcSelPin; // Select pins
	logic [31:0] portPinIn, portPinOut, portPinOe; // Port wire
	logic ioUpdatePin; // Update pin
	logic serialClk, serialDataIoIn, serialChipSelN, serialSyncAbort; // Serial copies
	logic serialDataOut = 1'b0, serialDataIoOut = 1'b0, serialDataIoOe = 1'b0; // Serial inputs
	logic [31:0] coreFreq; // Core words
	logic [15:0] corePhase;
	logic [11:0] coreAmp;
	int numErrors = 0; // Mismatches
	int nCompared = 0; // Comparisons
	int k; // Cycle counter
	// Codes, port words and the cumulative core words they give
	pfr_row_t rows [14] = '{
		'{4'h2, 32'h12345678, 32'h12345678, 16'h0000, 12'h000},
		'{4'h3, 32'haabbccdd, 32'hccddaabb, 16'h0000, 12'h000},
		'{4'h4, 32'h1357f9ab, 32'hccddaabb, 16'h1357, 12'h9ab},
		'{4'h5, 32'hf2460abc, 32'hccddaabb, 16'h0abc, 12'h246},
		'{4'h6, 32'h11223344, 32'h112233bb, 16'h0abc, 12'h446},
		'{4'h7, 32'h55667788, 32'h556677bb, 16'h88bc, 12'h446},
		'{4'h8, 32'h99aabbcc, 32'h99aabbbb, 16'h88bc, 12'h4cc},
		'{4'h9, 32'h0f1e2d3c, 32'h0f1e2dbb, 16'h883c, 12'h4cc},
		'{4'ha, 32'hdeadbe01, 32'h0fdeadbe, 16'h883c, 12'h1cc},
		'{4'hb, 32'h13579b77, 32'h0f13579b, 16'h773c, 12'h1cc},
		'{4'hc, 32'h2468ace5, 32'h0f2468ac, 16'h773c, 12'h1e5},
		'{4'hd, 32'hfedcba42, 32'h0ffedcba, 16'h7742, 12'h1e5},
		'{4'he, 32'hffffffff, 32'h0ffedcba, 16'h7742, 12'h1e5},
		'{4'hf, 32'h00000000, 32'h0ffedcba, 16'h7742, 12'h1e5}};
	// 10 MHz clock
	always #50 clk = ~clk;
	port_function_router i_port_function_router (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.funcSelPin(funcSelPin), .portPinIn(portPinIn), .portPinOut(portPinOut), .portPinOe(portPinOe),
		.ioUpdatePin(ioUpdatePin), .serialClk(serialClk), .serialDataIoIn(serialDataIoIn),
		.serialChipSelN(serialChipSelN), .serialSyncAbort(serialSyncAbort), .serialDataOut(serialDataOut),
		.serialDataIoOut(serialDataIoOut), .serialDataIoOe(serialDataIoOe), .coreFreq(coreFreq),
		.corePhase(corePhase), .coreAmp(coreAmp));
	pfr_host_model i_pfr_host_model (.clk(clk), .portPinOut(portPinOut), .portPinOe(portPinOe),
		.funcSelPin(funcSelPin), .portPinIn(portPinIn), .ioUpdatePin(ioUpdatePin));
	// Verdict and end of run
	task automatic tallyAndFinish();
		if (numErrors == 0 && nCompared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tallyAndFinish
	// One APB transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) numErrors++;
	endtask : apb
	// Register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic err;
		apb(1'b1, a, d, rd, err);
	endtask : wr
	// Register read against expected data and error flag
	task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input logic exErr);
		logic [31:0] rd;
		logic err;
		apb(1'b0, a, 32'h0, rd, err);
		`CHK("read data", ex, rd)
		`CHK("read error", exErr, err)
	endtask : rdc
	// Hang guard
	initial begin
		repeat (5000) @(posedge clk);
		numErrors++;
		tallyAndFinish();
	end
	// Main sequence
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		`CHK("idle outputs", {32'h0, 16'h0, 12'h0, 1'b1, 32'h0}, {coreFreq, corePhase, coreAmp, serialChipSelN, portPinOe})
		rdc(REG_CTRL0, CTRL0_RESET, 1'b0);
		rdc(REG_CTRL1, CTRL1_RESET, 1'b0);
		rdc(8'h40, 32'h0, 1'b1);
		wr(REG_CTRL0, 32'(1) << STREAM_BIT);
		wr(REG_CTRL1, 32'(1) << KEYING_BIT);
		wr(REG_FREQ, 32'hffffffff);
		rdc(REG_CTRL0, 32'h00020000, 1'b0);
		// Every direct and unused code, words accumulate
		foreach (rows[i]) begin
			i_pfr_host_model.apply(rows[i].code, rows[i].word, '1);
			`CHK("core words", rows[i][59:0], {coreFreq, corePhase, coreAmp})
		end
		rdc(REG_FREQ, 32'h0ffedcba, 1'b0);
		rdc(REG_STATUS, 32'h0000002f, 1'b0);
		// Keying off freezes amplitude only
		wr(REG_CTRL1, 32'h0);
		i_pfr_host_model.apply(4'h5, 32'h0fff1234, '1);
		`CHK("keying off", {16'h1234, 12'h1e5}, {corePhase, coreAmp})
		// Streaming off holds words until an update
		wr(REG_CTRL0, 32'h0);
		i_pfr_host_model.apply(4'h2, 32'h600dcafe, '1);
		`CHK("held freq", 32'h0ffedcba, coreFreq)
		rdc(REG_STATUS, 32'h00000012, 1'b0);
		i_pfr_host_model.pulse_update();
		`CHK("pin update", 32'h600dcafe, coreFreq)
		i_pfr_host_model.apply(4'h2, 32'h0badf00d, '1);
		wr(REG_UPDATE, 32'(1) << UPDATE_BIT);
		repeat (5) @(posedge clk);
		rdc(REG_FREQ, 32'h0badf00d, 1'b0);
		// Spacing of two samples, measured from one tick
		wr(REG_CTRL0, 32'(1) << STREAM_BIT);
		i_pfr_host_model.drive(4'h2, 32'h0000aaaa, '1);
		k = 0;
		do @(negedge clk); while (coreFreq !== 32'h0000aaaa && ++k < 60);
		i_pfr_host_model.drive(4'h2, 32'h0000bbbb, '1);
		k = 0;
		do begin @(negedge clk); k++; end while (coreFreq !== 32'h0000bbbb && k < 60);
		`CHK("sample spacing", SAMPLE_DIV, k)
		// Register programming through the port, wide then narrow
		i_pfr_host_model.apply(4'h0, 32'hbeef0505, '1);
		i_pfr_host_model.apply(4'h0, 32'h00000506, 32'h0000ffff);
		`CHK("wide read", {32'hffff0000, 16'hbeef}, {portPinOe, portPinOut[31:16]})
		i_pfr_host_model.apply(4'h0, 32'h005a0601, '1);
		i_pfr_host_model.apply(4'h0, 32'h00000602, 32'h0000ffff);
		`CHK("narrow read", {32'h00ff0000, 8'h5a}, {portPinOe, portPinOut[23:16]})
		// Serial pins on the low byte, device drives data lines
		serialDataOut <= 1'b1;
		serialDataIoOe <= 1'b1;
		i_pfr_host_model.apply(4'h1, 32'hffffff12, 32'hfffffff3);
		`CHK("serial pins", {4'b1001, 2'b11, 2'b10, 32'h0000bbbb}, {serialClk, serialDataIoIn, serialChipSelN,
			serialSyncAbort, portPinOe[3:2], portPinOut[3:2], coreFreq})
		// Swap the two device data lines so neither can stick
		serialDataOut <= 1'b0;
		serialDataIoOut <= 1'b1;
		i_pfr_host_model.apply(4'h1, 32'hffffff12, 32'hfffffff3);
		`CHK("serial data lines", 3'b101, {serialDataIoIn, portPinOut[3:2]})
		i_pfr_host_model.apply(4'he, 32'h12345678, '1);
		`CHK("unused code", {1'b1, 32'h0, 32'h0000bbbb}, {serialChipSelN, portPinOe, coreFreq})
		rdc(REG_STATUS, 32'h0000002e, 1'b0);
		// Mid-run reset brings outputs and controls back to idle
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		`CHK("reset outputs", {32'h0, 16'h0, 12'h0, 1'b1, 32'h0, 1'b0},
			{coreFreq, corePhase, coreAmp, serialChipSelN, portPinOe, pready})
		rdc(REG_CTRL0, CTRL0_RESET, 1'b0);
		rdc(REG_CTRL1, CTRL1_RESET, 1'b0);
		tallyAndFinish();
	end
endmodule : port_function_router_tb
